// ===== include/rfi_map.vh
/*
 * constants for the rotor fault indicator: configuration word offsets,
 * field positions, tick timing and the lock event limit.
 * assumes a 20 mhz system clock; included by bare name.
 */
`ifndef RFI_MAP_VH
`define RFI_MAP_VH

// configuration word offsets (nonvolatile word index)
`define RFI_OFS_LOCK_TIME_AND_MAX_FREQ 5'h0b
`define RFI_OFS_FAULT_SPEED_THRESHOLDS 5'h0c
`define RFI_OFS_FAULT_BLANK_AND_DELAY 5'h0d
`define RFI_OFS_RUN_MODE 5'h10

// field positions
`define RFI_LOCK_MODE_BIT 2
`define RFI_SET_SPEED_LSB 0
`define RFI_SET_SPEED_MSB 7
`define RFI_CLEAR_SPEED_LSB 8
`define RFI_CLEAR_SPEED_MSB 15
`define RFI_BLANK_LSB 0
`define RFI_BLANK_MSB 7
`define RFI_DELAY_LSB 8
`define RFI_DELAY_MSB 12
`define RFI_MAX_FREQ_LSB 0
`define RFI_MAX_FREQ_MSB 7
`define RFI_LOCK_OFF_LSB 8
`define RFI_LOCK_OFF_MSB 15

// speed thresholds step in 16 rpm units: shift of the 8-bit field
`define RFI_RPM_STEP_SHIFT 4

// timing
`define RFI_CLK_HZ 20000000
`define RFI_TICK_MS 100
`define RFI_TICK_CYCLES ((`RFI_CLK_HZ / 1000) * `RFI_TICK_MS)
`define RFI_TICKS_PER_SEC 10
`define RFI_LOCK_EVENT_LIMIT 2

`endif

// ===== rtl/rfi_tick_div.v
/*
 * rfi_tick_div: divides the system clock into a one-cycle enable pulse.
 * assumes a free-running clock and an asynchronous active-low reset.
 */
`timescale 1ns/100ps
module rfi_tick_div
#(
	parameter DIVIDE = 2000000
)
(
	input wire clk_sys, // system clock
	input wire rst_n, // asynchronous reset, active low
	input wire restart, // zero the divider phase
	output reg tick // one-cycle enable every DIVIDE clocks
);

reg [31:0] count;

// count up and pulse at the end of each period
always @(posedge clk_sys or negedge rst_n)
begin
	if (!rst_n)
	begin
		count <= 32'h0;
		tick <= 1'b0;
	end
	else if (restart)
	begin
		count <= 32'h0;
		tick <= 1'b0;
	end
	else if (count == DIVIDE - 1)
	begin
		count <= 32'h0;
		tick <= 1'b1;
	end
	else
	begin
		count <= count + 32'h1;
		tick <= 1'b0;
	end
end

endmodule

// ===== rtl/rfi_rotor_fault.v
/*
 * rfi_rotor_fault: rotor fault indicator. it watches measured speed, the
 * speed demand state and lock events, and drives an open-drain fault pin.
 * assumes the motor controller supplies speed in rpm, a run flag, a
 * start pulse, a lock pulse and an open-loop-done flag, and that the
 * configuration words are loaded over a simple synchronous write port.
 */
`timescale 1ns/100ps
`include "rfi_map.vh"

module rfi_rotor_fault
#(
	parameter TICK_CYCLES = `RFI_TICK_CYCLES, // clocks per 100 ms tick
	parameter SPEED_W = 16 // measured speed width in rpm
)
(
	input wire clk_sys, // system clock, 20 mhz
	input wire rst_n, // asynchronous reset, active low
	input wire cfg_wr, // configuration word write strobe
	input wire [4:0] cfg_addr, // configuration word index
	input wire [15:0] cfg_wdata, // configuration word write data
	input wire [SPEED_W-1:0] speed_rpm, // measured rotor speed in rpm
	input wire speed_demand_in, // speed demand active (drive enabled)
	input wire start_pulse, // one cycle at each motor start
	input wire lock_pulse, // one cycle when a rotor lock is detected
	input wire open_loop_done, // high once open-loop start has finished
	output reg [15:0] cfg_rdata, // configuration word read data
	output reg fault_o, // fault pin output level (always low when driven)
	output reg fault_oe_n, // fault pin enable, low pulls the pin low
	output reg fault_state, // fault indication, high is fault
	output reg [1:0] lock_count // lock event counter
);

////////////////////////////////////////////////////////////////////////////////

reg [15:0] lock_time_and_max_freq;
reg [15:0] fault_speed_thresholds;
reg [15:0] fault_blank_and_delay;
reg [15:0] run_mode;

// configuration word writes
always @(posedge clk_sys or negedge rst_n)
begin
	if (!rst_n)
	begin
		lock_time_and_max_freq <= 16'h0000;
		fault_speed_thresholds <= 16'h0000;
		fault_blank_and_delay <= 16'h0000;
		run_mode <= 16'h0000;
	end
	else if (cfg_wr)
	begin
		case (cfg_addr)
		`RFI_OFS_LOCK_TIME_AND_MAX_FREQ: lock_time_and_max_freq <= cfg_wdata;
		`RFI_OFS_FAULT_SPEED_THRESHOLDS: fault_speed_thresholds <= cfg_wdata;
		`RFI_OFS_FAULT_BLANK_AND_DELAY: fault_blank_and_delay <= cfg_wdata;
		`RFI_OFS_RUN_MODE: run_mode <= cfg_wdata;
		default: ;
		endcase
	end
end

// configuration word readback, unmapped reads as zero
always @(posedge clk_sys or negedge rst_n)
begin
	if (!rst_n)
		cfg_rdata <= 16'h0000;
	else
	begin
		case (cfg_addr)
		`RFI_OFS_LOCK_TIME_AND_MAX_FREQ: cfg_rdata <= lock_time_and_max_freq;
		`RFI_OFS_FAULT_SPEED_THRESHOLDS: cfg_rdata <= fault_speed_thresholds;
		`RFI_OFS_FAULT_BLANK_AND_DELAY: cfg_rdata <= {3'h0, fault_blank_and_delay[12:0]};
		`RFI_OFS_RUN_MODE: cfg_rdata <= run_mode;
		default: cfg_rdata <= 16'h0000;
		endcase
	end
end

////////////////////////////////////////////////////////////////////////////////

// field extraction and threshold scaling to rpm
wire lock_mode_select = run_mode[`RFI_LOCK_MODE_BIT];
wire [7:0] fault_set_field = fault_speed_thresholds[`RFI_SET_SPEED_MSB:`RFI_SET_SPEED_LSB];
wire [7:0] fault_clear_field = fault_speed_thresholds[`RFI_CLEAR_SPEED_MSB:`RFI_CLEAR_SPEED_LSB];
wire [7:0] fault_blank_time = fault_blank_and_delay[`RFI_BLANK_MSB:`RFI_BLANK_LSB];
wire [4:0] delay_field = fault_blank_and_delay[`RFI_DELAY_MSB:`RFI_DELAY_LSB];
wire [3:0] speed_fault_delay = (delay_field > 5'h0f) ? 4'hf : delay_field[3:0];
wire [15:0] fault_set_speed = {4'h0, fault_set_field, 4'h0}; // 16 rpm steps
wire [15:0] fault_clear_speed = {4'h0, fault_clear_field, 4'h0};
wire [15:0] speed16 = speed_rpm[15:0];
wire func_enable = (fault_clear_field != 8'h00);
wire speed_low = speed16 < fault_set_speed;
wire speed_high = speed16 > fault_clear_speed;

////////////////////////////////////////////////////////////////////////////////

// 100 ms base tick and 1 s tick from the system clock
wire tick_100ms;
reg [3:0] sec_div;
reg tick_1s;

rfi_tick_div #(.DIVIDE(TICK_CYCLES)) u_tick
(
	.clk_sys(clk_sys),
	.rst_n(rst_n),
	.restart(1'b0),
	.tick(tick_100ms)
);

// ten 100 ms ticks per second
always @(posedge clk_sys or negedge rst_n)
begin
	if (!rst_n)
	begin
		sec_div <= 4'h0;
		tick_1s <= 1'b0;
	end
	else if (tick_100ms)
	begin
		sec_div <= (sec_div == 4'd9) ? 4'h0 : sec_div + 4'h1;
		tick_1s <= (sec_div == 4'd9);
	end
	else
		tick_1s <= 1'b0;
end

////////////////////////////////////////////////////////////////////////////////

reg [7:0] blank_cnt;
reg blank_active;
reg [3:0] dly_cnt;
reg [1:0] dly_kind; // 0 none, 1 raise, 2 lower, 3 demand-off
reg demand_d;
// blank_done only fires while demand is on, so a stop on demand never raises the pin
wire blank_done = blank_active && speed_demand_in && tick_100ms && (blank_cnt <= 8'h01);
wire demand_off = demand_d && !speed_demand_in;
wire new_start = start_pulse || lock_pulse;
wire [1:0] next_kind = !speed_demand_in ? (fault_state ? 2'd3 : 2'd0) :
	(!fault_state && speed_low) ? 2'd1 :
	(fault_state && speed_high && !blank_active) ? 2'd2 : 2'd0; // held until blank end
wire dly_done = (dly_kind != 2'd0) && (next_kind == dly_kind) &&
	((dly_cnt >= speed_fault_delay) || (speed_fault_delay == 4'h0));

// blanking timer, started by each start or lock while demand is on
always @(posedge clk_sys or negedge rst_n)
begin
	if (!rst_n)
	begin
		blank_cnt <= 8'h00;
		blank_active <= 1'b0;
		demand_d <= 1'b0;
	end
	else
	begin
		demand_d <= speed_demand_in;
		if (new_start && speed_demand_in)
		begin
			blank_cnt <= fault_blank_time;
			blank_active <= 1'b1;
		end
		else if (!speed_demand_in)
		begin
			blank_active <= 1'b0;
		end
		else if (blank_done)
		begin
			blank_active <= 1'b0;
		end
		else if (blank_active && tick_100ms)
			blank_cnt <= blank_cnt - 8'h01;
	end
end

// delay timer, restarts whenever the pending condition changes
always @(posedge clk_sys or negedge rst_n)
begin
	if (!rst_n)
	begin
		dly_cnt <= 4'h0;
		dly_kind <= 2'd0;
	end
	else if (next_kind != dly_kind || dly_done)
	begin
		dly_cnt <= 4'h0;
		dly_kind <= dly_done ? 2'd0 : next_kind;
	end
	else if (tick_1s && dly_cnt != 4'hf)
		dly_cnt <= dly_cnt + 4'h1;
end

////////////////////////////////////////////////////////////////////////////////

// lock event counter in counter mode
always @(posedge clk_sys or negedge rst_n)
begin
	if (!rst_n)
		lock_count <= 2'd0;
	else if (!func_enable || lock_mode_select)
		lock_count <= 2'd0;
	else if (lock_pulse && lock_count != `RFI_LOCK_EVENT_LIMIT)
		lock_count <= lock_count + 2'd1;
	else if (blank_done && speed_high)
		lock_count <= 2'd0;
end

// fault decision
always @(posedge clk_sys or negedge rst_n)
begin
	if (!rst_n)
		fault_state <= 1'b0;
	else if (!func_enable)
		fault_state <= open_loop_done;
	else if (!lock_mode_select && lock_pulse && lock_count == 2'd1)
		fault_state <= 1'b1; // second lock event
	else if (blank_done)
	begin
		if (speed_high)
			fault_state <= 1'b0;
		else
			fault_state <= 1'b1;
	end
	else if (dly_done)
	begin
		case (dly_kind)
		2'd1: fault_state <= 1'b1;
		2'd2: fault_state <= 1'b0;
		2'd3: fault_state <= 1'b0;
		default: fault_state <= fault_state;
		endcase
	end
	else if (demand_off && !fault_state)
		fault_state <= 1'b0;
end

// pin release follows the fault level
wire next_pin_release = fault_state;

// open-drain pin: enable low pulls low, released means fault high
always @(posedge clk_sys or negedge rst_n)
begin
	if (!rst_n)
	begin
		fault_o <= 1'b0;
		fault_oe_n <= 1'b0;
	end
	else
	begin
		fault_o <= 1'b0;
		fault_oe_n <= next_pin_release;
	end
end

endmodule

// ===== dv/rfi_host_mon.sv
/* rfi_host_mon: host side that reads the open-drain fault pin.
   assumes a pull-up on the pin and no other driver. */
`timescale 1ns/100ps
module rfi_host_mon
(
	input wire fault_o, // pin drive level from the block
	input wire fault_oe_n, // pin drive enable, low drives
	output wire pin_level // level the host sees
);
	// the pull-up wins while the block releases the pin
	assign pin_level = fault_oe_n ? 1'b1 : fault_o;
endmodule

// ===== dv/rfi_rotor_fault_chk.sv
/* rfi_rotor_fault_chk: port assertions for the fault indicator.
   assumes one clock domain and an async active-low reset. */
`timescale 1ns/100ps
module rfi_rotor_fault_chk
#(
	parameter TICK_CYCLES = 20, // clocks per tick
	parameter SPEED_W = 16 // speed width
)
(
	input wire clk_sys, // clock
	input wire rst_n, // reset
	input wire cfg_wr, // write strobe
	input wire [4:0] cfg_addr, // word index
	input wire [15:0] cfg_wdata, // write data
	input wire [SPEED_W-1:0] speed_rpm, // speed
	input wire speed_demand_in, // demand
	input wire start_pulse, // start
	input wire lock_pulse, // lock
	input wire open_loop_done, // open loop finished
	input wire [15:0] cfg_rdata, // read data
	input wire fault_o, // pin level
	input wire fault_oe_n, // pin enable
	input wire fault_state, // fault
	input wire [1:0] lock_count // lock events
);
	reg mode;
	reg dis;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	////////////////////////////////////////////////////////////////
	// shadow of lock mode and of the disabled state
	always @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			mode <= 1'b0;
			dis <= 1'b1;
		end
		else if (cfg_wr && cfg_addr == 5'h10)
			mode <= cfg_wdata[2];
		else if (cfg_wr && cfg_addr == 5'h0c)
			dis <= (cfg_wdata[15:8] == 8'h00);
	end
	////////////////////////////////////////////////////////////////
	// assertions
	AST_PIN_LOW: assert property (fault_o == 1'b0)
		else $error("fault pin drive level high");
	AST_OE_FOLLOW: assert property (fault_oe_n == $past(fault_state))
		else $error("pin enable does not follow fault");
	AST_LOCK_TWO: assert property (!mode && !dis && speed_demand_in && lock_pulse
		&& lock_count == 2'd1 |=> fault_state) else $error("second lock without fault");
	AST_DIS_FOLLOW: assert property (dis && $rose(open_loop_done) |-> ##[1:2] fault_state)
		else $error("disabled pin not raised at open loop end");
	AST_MODE_READ: assert property (cfg_addr == 5'h10 && !cfg_wr ##1 cfg_addr == 5'h10
		|-> cfg_rdata[2] == mode) else $error("mode bit readback wrong");
	AST_RESET_LOW: assert property ($rose(rst_n) |-> !fault_state && !fault_oe_n
		&& lock_count == 2'd0) else $error("outputs not clear after reset");
	AST_CNT_STEP: assert property ($changed(lock_count) |-> lock_count == 2'd0
		|| lock_count == $past(lock_count) + 2'd1) else $error("lock count jumped");
	AST_DEMAND_OFF: assert property ($fell(speed_demand_in) && !fault_state
		|=> !fault_state [*8]) else $error("fault raised on demand off");
	// main scenarios
	cover property (lock_count == 2'd2);
	cover property ($rose(fault_state) && mode);
	cover property ($fell(fault_state) && !mode);
endmodule

// ===== dv/rfi_rotor_fault_tb_top.sv
/* rfi_rotor_fault_tb_top: self-checking bench for the fault indicator.
   assumes a 20-clock tick, so one second is 200 clocks. */
`timescale 1ns/100ps
module rfi_rotor_fault_tb_top;
	reg clk_sys = 1'b0;
	reg rst_n = 1'b0;
	reg cfg_wr = 1'b0;
	reg [4:0] cfg_addr = 5'h00;
	reg [15:0] cfg_wdata = 16'h0000;
	reg [15:0] speed_rpm = 16'h0000;
	reg speed_demand_in = 1'b0;
	reg start_pulse = 1'b0;
	reg lock_pulse = 1'b0;
	reg open_loop_done = 1'b0;
	wire [15:0] cfg_rdata;
	wire fault_o;
	wire fault_oe_n;
	wire fault_state;
	wire [1:0] lock_count;
	wire pin_level;
	integer fail_count = 0;
	integer checked = 0;
	////////////////////////////////////////////////////////////////
	// block and host
	rfi_rotor_fault #(.TICK_CYCLES(20), .SPEED_W(16)) dut_u (.clk_sys(clk_sys), .rst_n(rst_n),
		.cfg_wr(cfg_wr), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .speed_rpm(speed_rpm),
		.speed_demand_in(speed_demand_in), .start_pulse(start_pulse), .lock_pulse(lock_pulse),
		.open_loop_done(open_loop_done), .cfg_rdata(cfg_rdata), .fault_o(fault_o),
		.fault_oe_n(fault_oe_n), .fault_state(fault_state), .lock_count(lock_count));
	rfi_host_mon host_u (.fault_o(fault_o), .fault_oe_n(fault_oe_n), .pin_level(pin_level));
	// clock
	initial
	begin
		forever #25 clk_sys = ~clk_sys;
	end
	////////////////////////////////////////////////////////////////
	// helpers: all inputs change 5 ns after a rising edge
	task step(input integer n);
	begin
		repeat (n) @(posedge clk_sys);
		#5;
	end
	endtask
	task chk(input string what, input [15:0] exp, input [15:0] got);
	begin
		checked = checked + 1;
		if (got !== exp)
		begin
			fail_count = fail_count + 1;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	end
	endtask
	task wr(input [4:0] a, input [15:0] d);
	begin
		cfg_wr = 1'b1;
		cfg_addr = a;
		cfg_wdata = d;
		step(1);
		cfg_wr = 1'b0;
		step(1); // an edge passes between two writes
	end
	endtask
	task rdchk(input [4:0] a, input [15:0] exp);
	begin
		cfg_addr = a;
		step(2);
		chk("cfg_rdata", exp, cfg_rdata);
	end
	endtask
	task pls(input is_lock);
	begin
		lock_pulse = is_lock;
		start_pulse = !is_lock;
		step(1);
		lock_pulse = 1'b0;
		start_pulse = 1'b0;
		step(1); // an edge passes between two pulses
	end
	endtask
	////////////////////////////////////////////////////////////////
	// scenarios
	task t_dis;
	begin
		chk("pin", 16'h0, pin_level);
		chk("lock_count", 16'h0, lock_count);
		wr(5'h0c, 16'h0000);
		open_loop_done = 1'b1;
		step(4);
		chk("pin", 16'h1, pin_level);
		open_loop_done = 1'b0;
		$display("test disabled done");
	end
	endtask
	task t_regs;
	begin
		wr(5'h0c, 16'h8040); // set 1024 below clear 2048
		wr(5'h0d, 16'h0203);
		wr(5'h10, 16'h0004);
		rdchk(5'h0c, 16'h8040);
		rdchk(5'h0d, 16'h0203);
		rdchk(5'h10, 16'h0004);
		rdchk(5'h1f, 16'h0000);
		$display("test registers done");
	end
	endtask
	task t_start;
	begin
		speed_demand_in = 1'b1;
		speed_rpm = 16'd1600; // above set, below clear
		pls(0);
		step(30);
		chk("pin", 16'h0, pin_level); // blank of three ticks still running
		step(60);
		chk("pin", 16'h1, pin_level);
		speed_rpm = 16'd2064;
		step(150);
		chk("pin", 16'h1, pin_level);
		step(300);
		chk("pin", 16'h0, pin_level);
		speed_rpm = 16'd1008;
		step(150);
		chk("pin", 16'h0, pin_level);
		step(300);
		chk("pin", 16'h1, pin_level);
		speed_demand_in = 1'b0;
		step(450);
		chk("pin", 16'h0, pin_level);
		speed_demand_in = 1'b1;
		speed_rpm = 16'd3000;
		pls(0);
		step(90);
		speed_demand_in = 1'b0;
		step(50);
		chk("pin", 16'h0, pin_level);
		$display("test start and delay done");
	end
	endtask
	task t_cnt;
	begin
		wr(5'h10, 16'h0000);
		speed_demand_in = 1'b1;
		speed_rpm = 16'd0;
		pls(0);
		pls(1);
		chk("lock_count", 16'h1, lock_count);
		chk("fault_state", 16'h0, fault_state);
		pls(1);
		step(1);
		chk("fault_state", 16'h1, fault_state);
		speed_rpm = 16'd3000;
		step(90);
		chk("pin", 16'h0, pin_level);
		chk("lock_count", 16'h0, lock_count);
		$display("test lock counter done");
	end
	endtask
	task t_blk;
	begin
		wr(5'h0d, 16'h0132); // blank 5 s outlasts start
		wr(5'h10, 16'h0004);
		pls(0);
		step(1100);
		pls(1);
		speed_rpm = 16'd1008;
		step(250);
		chk("pin", 16'h1, pin_level);
		speed_rpm = 16'd3000;
		step(300);
		chk("pin", 16'h1, pin_level);
		step(500);
		chk("pin", 16'h0, pin_level);
		$display("test blanking lock done");
	end
	endtask
	////////////////////////////////////////////////////////////////
	// verdict, main sequence and watchdog
	task print_verdict;
	begin
		$display("checks %0d, mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	end
	endtask
	initial
	begin
		step(12);
		rst_n = 1'b1;
		step(2);
		t_dis;
		t_regs;
		t_start;
		t_cnt;
		t_blk;
		print_verdict;
	end
	initial
	begin
		#1000000;
		fail_count = fail_count + 1;
		print_verdict;
	end
endmodule
// checker on the block ports
bind rfi_rotor_fault rfi_rotor_fault_chk #(.TICK_CYCLES(TICK_CYCLES), .SPEED_W(SPEED_W)) chk_u (
	.clk_sys(clk_sys), .rst_n(rst_n), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr),
	.cfg_wdata(cfg_wdata), .speed_rpm(speed_rpm), .speed_demand_in(speed_demand_in),
	.start_pulse(start_pulse), .lock_pulse(lock_pulse), .open_loop_done(open_loop_done),
	.cfg_rdata(cfg_rdata), .fault_o(fault_o), .fault_oe_n(fault_oe_n),
	.fault_state(fault_state), .lock_count(lock_count));
